// ---- rtl/mc_timer.sv ----
// Purpose: Machine-cycle counter for the wake-up reset pulse.
// Assumes: One machine cycle is MC_CLKS clocks of clk_sys.
// Notes:   Saturates at all ones so a very long external reset never wraps.
`timescale 1ns/100ps
`default_nettype none
`include "pdwake_params.svh"
module mc_timer #(
  parameter int MC_CLKS = `MC_CLKS
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset
  input wire logic clear, // Restart from zero
  input wire logic run, // Count while high
  output logic [`MC_CNT_W-1:0] mc_count // Machine cycles elapsed
);
  logic [7:0] clk_cnt_ff, nxt_clk_cnt;
  logic [`MC_CNT_W-1:0] mc_ff, nxt_mc;

  // Divide clocks into machine cycles
  always_comb begin
    nxt_clk_cnt = clk_cnt_ff;
    nxt_mc = mc_ff;
    if (clear) begin
      nxt_clk_cnt = 8'h00;
      nxt_mc = '0;
    end else if (run) begin
      if (clk_cnt_ff == 8'(MC_CLKS - 1)) begin
        nxt_clk_cnt = 8'h00;
        if (mc_ff != '1) begin
          nxt_mc = mc_ff + 1'b1;
        end
      end else begin
        nxt_clk_cnt = clk_cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_cnt_ff <= 8'h00;
      mc_ff <= '0;
    end else begin
      clk_cnt_ff <= nxt_clk_cnt;
      mc_ff <= nxt_mc;
    end
  end

  assign mc_count = mc_ff;
endmodule
`default_nettype wire

// ---- rtl/pdwake_params.svh ----
// Purpose: Offsets, field positions, reset values and counts for the
//          power-down and wake-up controller.
// Assumes: 32-bit register port, one word per register.
// Notes:   Counts in machine cycles unless named _CLKS.
`ifndef PDWAKE_PARAMS_SVH
`define PDWAKE_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_INTERRUPT_ENABLE_REG0 8'h04
`define OFS_STATUS 8'h08
`define OFS_MASK 8'h0c
`define OFS_STATE 8'h10

// Control register fields
`define CTRL_IDLE_BIT 0
`define CTRL_PD_BIT 1

// Interrupt enable register fields
`define IEN_GLOBAL_BIT 7
`define IEN_CAN_BIT 5

// Sticky status fields
`define ST_PD_ENTRY 0
`define ST_CAN_WAKE 1
`define ST_CAN_PART_RST 2
`define ST_IDLE_EXIT 3
`define ST_WIDTH 4

// Reset values
`define CTRL_RST 8'h00
`define IEN_RST 8'h00
`define MASK_RST 4'h0

// CAN controller command register sleep bit
`define CAN_SLEEP_BIT 4

// Timing: machine cycles
`define WAKE_PULSE_MC 6144
`define CAN_RST_MC 8192
`define MC_CLKS 12
`define MC_CNT_W 14

`endif

// ---- rtl/pdwake_pkg.sv ----
// Purpose: Types shared by the power-down and wake-up controller.
// Assumes: Nothing beyond the params header.
// Notes:   State codes follow declaration order, from zero.
package pdwake_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE,
    ST_PDOWN,
    ST_WAKE
  } pd_state_t;
endpackage

// ---- rtl/power_down_wakeup_control.sv ----
// Purpose: Power-down entry, CAN wake-up reset pulse and pin states in
//          idle and power-down.
// Assumes: clk_sys keeps running for this block; osc_run tells the rest
//          of the chip whether its oscillator runs.
// Notes:   Register port: read data valid in the cycle after reg_rd.
// Summary of operation
// - Setting the power-down bit ends execution and stops the oscillator.
// - Setting the power-down bit forces the CAN command sleep bit to one.
// - Power-down ends only on hardware reset or an enabled CAN wake-up.
// - Hardware reset clears all CPU and CAN registers but keeps RAM.
// - CAN wake-up drives a 6144 machine-cycle reset pulse, also on the pin.
// - The wake-up pulse resets everything except the CAN controller; here the status and mask registers keep their values.
// - A pulse stretched past 8192 machine cycles also resets the CAN part.
// - Idle keeps strobes and pulse-width outputs high, port 2 as address when ext_prog.
// - Power-down drives strobes low, pulse-width high, ports hold data.
// - CAN transmit outputs used as transmitter go recessive in sleep and power-down.
`timescale 1ns/100ps
`default_nettype none
`include "pdwake_params.svh"
module power_down_wakeup_control
  import pdwake_pkg::*;
#(
  parameter int WAKE_MC = `WAKE_PULSE_MC,
  parameter int CAN_RST_MC = `CAN_RST_MC,
  parameter int MC_CLKS = `MC_CLKS
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Hardware reset, async
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after reg_rd
  input wire logic can_rx_dom, // Bus level is dominant
  input wire logic can_asleep, // CAN controller reports sleep
  input wire logic ext_prog, // External program memory in use
  input wire logic cpu_irq_any, // Any enabled interrupt request
  input wire logic can_tx_is_out, // CAN tx pins used as transmitter
  input wire logic [1:0] can_tx_core, // CAN transmit data from core
  input wire logic ale_core, // Address latch strobe from core
  input wire logic program_store_strobe_core, // Program strobe from core
  input wire logic [1:0] pwm_core, // Pulse-width outputs from core
  input wire logic port2_addr_core, // Port 2 carries address in run
  input wire logic port0_float_core, // Port 0 floats in run
  input wire logic rst_pin_in, // Level seen on reset pin
  output logic reset_pin_out, // Reset pin drive value
  output logic reset_pin_oe_n, // Reset pin driven while low
  output logic osc_run, // Oscillator enable
  output logic cpu_halt, // Stop instruction execution
  output logic sys_reset, // Reset for all but CAN controller
  output logic can_reset, // Reset for CAN controller registers
  output logic can_sleep_set, // Force CAN command sleep bit
  output logic ale_pin, // Address latch strobe pin
  output logic program_store_strobe, // Program store strobe pin
  output logic [1:0] pwm_pin, // Pulse-width output pins
  output logic port0_float, // Port 0 released
  output logic port2_addr, // Port 2 drives address
  output logic port_hold, // Ports hold latched data
  output logic can_tx_out0, // CAN transmit pin 0
  output logic can_tx_out1, // CAN transmit pin 1
  output logic irq // Level interrupt
);
  pd_state_t state_ff, nxt_state;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] interrupt_enable_reg0_ff, nxt_ien;
  logic [`ST_WIDTH-1:0] status_ff, nxt_status, ev_set;
  logic [`ST_WIDTH-1:0] mask_ff, nxt_mask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic osc_ff, halt_ff, sysrst_ff, canrst_ff, sleep_ff, pin_oe_n_ff;
  logic nxt_osc, nxt_halt, nxt_sysrst, nxt_canrst, nxt_sleep, nxt_pin_oe_n;
  logic ale_ff, pss_ff, p0f_ff, p2a_ff, hold_ff, irq_ff;
  logic nxt_ale, nxt_pss, nxt_p0f, nxt_p2a, nxt_hold, nxt_irq;
  logic [1:0] pwm_ff, nxt_pwm, ctx_ff, nxt_ctx;
  logic [`MC_CNT_W-1:0] mc_count;
  logic tmr_clear, tmr_run, wake_req, pulse_done, can_long;
  logic wr_ctrl, wr_ien, wr_status, wr_mask;

  // Register decode
  assign wr_ctrl = reg_wr && reg_addr == `OFS_CTRL;
  assign wr_ien = reg_wr && reg_addr == `OFS_INTERRUPT_ENABLE_REG0;
  assign wr_status = reg_wr && reg_addr == `OFS_STATUS;
  assign wr_mask = reg_wr && reg_addr == `OFS_MASK;

  // Wake needs global and CAN source enables; sampled on clk_sys,
  // which stands in for the unclocked detector of the real part
  assign wake_req = can_rx_dom &&
    interrupt_enable_reg0_ff[`IEN_GLOBAL_BIT] &&
    interrupt_enable_reg0_ff[`IEN_CAN_BIT];
  assign pulse_done = mc_count >= `MC_CNT_W'(WAKE_MC);
  assign can_long = mc_count > `MC_CNT_W'(CAN_RST_MC);

  // Reset pulse timer, held clear through power-down, counts in wake
  assign tmr_clear = state_ff == ST_PDOWN;
  assign tmr_run = state_ff == ST_WAKE;

  mc_timer #(
    .MC_CLKS(MC_CLKS)
  ) u_mc_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(tmr_clear),
    .run(tmr_run),
    .mc_count(mc_count)
  );

  // Mode sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (wr_ctrl && reg_wdata[`CTRL_PD_BIT]) begin
          nxt_state = ST_PDOWN;
        end else if (wr_ctrl && reg_wdata[`CTRL_IDLE_BIT]) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cpu_irq_any) begin
          nxt_state = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (wake_req) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // External capacitor on the pin keeps us here past the count
        if (pulse_done && !rst_pin_in) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  // Software registers; wake pulse clears the CPU-side ones only
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ien = interrupt_enable_reg0_ff;
    nxt_mask = mask_ff;
    if (state_ff == ST_WAKE) begin
      nxt_ctrl = `CTRL_RST;
      nxt_ien = `IEN_RST;
    end else begin
      if (wr_ctrl) begin
        nxt_ctrl = reg_wdata[7:0];
      end
      if (wr_ien) begin
        nxt_ien = reg_wdata[7:0];
      end
      if (state_ff == ST_IDLE && cpu_irq_any) begin
        nxt_ctrl[`CTRL_IDLE_BIT] = 1'b0;
      end
    end
    if (wr_mask) begin
      nxt_mask = reg_wdata[`ST_WIDTH-1:0];
    end
  end

  // Sticky events; a new event beats a write-one clear
  always_comb begin
    ev_set = '0;
    ev_set[`ST_PD_ENTRY] = state_ff == ST_RUN && nxt_state == ST_PDOWN;
    ev_set[`ST_CAN_WAKE] = state_ff == ST_PDOWN && nxt_state == ST_WAKE;
    ev_set[`ST_CAN_PART_RST] = state_ff == ST_WAKE && can_long && !canrst_ff;
    ev_set[`ST_IDLE_EXIT] = state_ff == ST_IDLE && nxt_state == ST_RUN;
    nxt_status = status_ff;
    if (wr_status) begin
      nxt_status = status_ff & ~reg_wdata[`ST_WIDTH-1:0];
    end
    nxt_status = nxt_status | ev_set;
    nxt_irq = |(nxt_status & nxt_mask);
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_CTRL: nxt_rdata[7:0] = ctrl_ff;
        `OFS_INTERRUPT_ENABLE_REG0: nxt_rdata[7:0] = interrupt_enable_reg0_ff;
        `OFS_STATUS: nxt_rdata[`ST_WIDTH-1:0] = status_ff;
        `OFS_MASK: nxt_rdata[`ST_WIDTH-1:0] = mask_ff;
        `OFS_STATE: begin
          nxt_rdata[2:0] = state_ff;
          nxt_rdata[4] = osc_ff;
          nxt_rdata[5] = canrst_ff;
          nxt_rdata[6] = can_asleep;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Clock, reset and sleep controls from the next mode
  always_comb begin
    nxt_osc = nxt_state != ST_PDOWN;
    nxt_halt = nxt_state == ST_PDOWN || nxt_state == ST_IDLE ||
      nxt_state == ST_WAKE;
    nxt_sysrst = nxt_state == ST_WAKE;
    nxt_pin_oe_n = nxt_state != ST_WAKE;
    // CAN part joins the reset only once the pulse is long
    nxt_canrst = nxt_state == ST_WAKE && (canrst_ff || can_long);
    // Held through power-down so the sleep bit cannot drop early
    nxt_sleep = nxt_state == ST_PDOWN;
  end

  // Pin states per mode
  always_comb begin
    nxt_ale = ale_core;
    nxt_pss = program_store_strobe_core;
    nxt_pwm = pwm_core;
    nxt_p0f = port0_float_core;
    nxt_p2a = port2_addr_core;
    nxt_hold = 1'b0;
    unique case (nxt_state)
      ST_IDLE: begin
        nxt_ale = 1'b1;
        nxt_pss = 1'b1;
        nxt_pwm = 2'h3;
        nxt_p0f = ext_prog;
        nxt_p2a = ext_prog;
        nxt_hold = 1'b1;
      end
      ST_PDOWN: begin
        nxt_ale = 1'b0;
        nxt_pss = 1'b0;
        nxt_pwm = 2'h3;
        nxt_p0f = ext_prog;
        nxt_p2a = 1'b0;
        nxt_hold = 1'b1;
      end
      ST_RUN, ST_WAKE: begin
        nxt_hold = 1'b0;
      end
    endcase
  end

  // CAN transmit pins, recessive (high) when used as transmitter and asleep or powered down
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ctx
      always_comb begin
        nxt_ctx[gi] = can_tx_core[gi];
        if (can_tx_is_out && (can_asleep || nxt_state == ST_PDOWN)) begin
          nxt_ctx[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // Hardware reset clears every register here; RAM lies outside
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_RUN;
      ctrl_ff <= `CTRL_RST;
      interrupt_enable_reg0_ff <= `IEN_RST;
      status_ff <= '0;
      mask_ff <= `MASK_RST;
      rdata_ff <= 32'h0000_0000;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      interrupt_enable_reg0_ff <= nxt_ien;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  // Control and pin registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_ff <= 1'b1;
      halt_ff <= 1'b0;
      sysrst_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
      canrst_ff <= 1'b0;
      sleep_ff <= 1'b0;
      ale_ff <= 1'b1;
      pss_ff <= 1'b1;
      pwm_ff <= 2'h3;
      p0f_ff <= 1'b1;
      p2a_ff <= 1'b0;
      hold_ff <= 1'b0;
      ctx_ff <= 2'h3;
    end else begin
      osc_ff <= nxt_osc;
      halt_ff <= nxt_halt;
      sysrst_ff <= nxt_sysrst;
      pin_oe_n_ff <= nxt_pin_oe_n;
      canrst_ff <= nxt_canrst;
      sleep_ff <= nxt_sleep;
      ale_ff <= nxt_ale;
      pss_ff <= nxt_pss;
      pwm_ff <= nxt_pwm;
      p0f_ff <= nxt_p0f;
      p2a_ff <= nxt_p2a;
      hold_ff <= nxt_hold;
      ctx_ff <= nxt_ctx;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_ff;
  assign reset_pin_out = sysrst_ff;
  assign reset_pin_oe_n = pin_oe_n_ff;
  assign osc_run = osc_ff;
  assign cpu_halt = halt_ff;
  assign sys_reset = sysrst_ff;
  assign can_reset = canrst_ff;
  assign can_sleep_set = sleep_ff;
  assign ale_pin = ale_ff;
  assign program_store_strobe = pss_ff;
  assign pwm_pin = pwm_ff;
  assign port0_float = p0f_ff;
  assign port2_addr = p2a_ff;
  assign port_hold = hold_ff;
  assign can_tx_out0 = ctx_ff[0];
  assign can_tx_out1 = ctx_ff[1];
  assign irq = irq_ff;
endmodule
`default_nettype wire

// ---- testbench/can_bus_model.sv ----
// Purpose: Far side: CAN bus activity and reset pin capacitor.
// Assumes: Bus recessive unless a frame starts.
// Notes: Big cap (long_cap) holds the pin a fixed time after drive begins.
`timescale 1ns/100ps
`default_nettype none
module can_bus_model #(
  parameter int CAP_CLKS = 40
) (
  input wire logic clk_sys, // Clock
  input wire logic send_dom, // Start frame
  input wire logic long_cap, // Big cap
  input wire logic reset_pin_out, // Pin value
  input wire logic reset_pin_oe_n, // Pin drive
  input wire logic hw_rst, // Button
  output logic can_rx_dom, // Dominant
  output logic rst_pin_in // Pin level
);
  logic [2:0] dom_ff = 3'h0;
  logic [7:0] cap_ff = 8'h0;
  logic drv_ff = 1'b0;
  logic drv;
  assign drv = reset_pin_out & ~reset_pin_oe_n;
  // Frame start: a few dominant clocks, then recessive idle
  always @(posedge clk_sys) begin
    if (send_dom) dom_ff <= 3'h4;
    else if (dom_ff != 3'h0) dom_ff <= dom_ff - 3'h1;
    drv_ff <= drv;
    if (drv && !drv_ff && long_cap) cap_ff <= CAP_CLKS[7:0];
    else if (cap_ff != 8'h0) cap_ff <= cap_ff - 8'h1;
  end
  assign can_rx_dom = dom_ff != 3'h0;
  // Own drive not fed back, else the pulse could never end
  assign rst_pin_in = hw_rst | (cap_ff != 8'h0);
endmodule
`default_nettype wire

// ---- testbench/pdwake_asserts.sv ----
// Purpose: Port checks for power-down and wake-up.
// Assumes: Parameters follow the instance.
// Notes: Pulse age counted in clk_sys cycles.
`timescale 1ns/100ps
`default_nettype none
`include "pdwake_params.svh"
module pdwake_asserts #(
  parameter int WAKE_MC = 6,
  parameter int CAN_RST_MC = 8,
  parameter int MC_CLKS = 2
) (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [31:0] reg_wdata, // Data
  input wire logic reg_wr, // Write
  input wire logic can_rx_dom, // Dominant
  input wire logic can_tx_is_out, // Tx as CAN
  input wire logic osc_run, // Oscillator
  input wire logic cpu_halt, // Halted
  input wire logic sys_reset, // Reset out
  input wire logic can_reset, // CAN reset
  input wire logic can_sleep_set, // Sleep force
  input wire logic reset_pin_out, // Pin value
  input wire logic reset_pin_oe_n, // Pin drive
  input wire logic ale_pin, // Latch strobe
  input wire logic program_store_strobe, // Store strobe
  input wire logic [1:0] pwm_pin, // Pulse width
  input wire logic port2_addr, // Port 2
  input wire logic port_hold, // Hold
  input wire logic can_tx_out0, // Tx 0
  input wire logic can_tx_out1 // Tx 1
);
  logic [15:0] hi_ff;
  logic [15:0] nxt_hi;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Pulse age, so long pulses need no long repetition
  always_comb nxt_hi = sys_reset ? hi_ff + 16'h1 : 16'h0;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) hi_ff <= 16'h0;
    else hi_ff <= nxt_hi;
  // Entry takes two steps: the write in run, then the halted state
  sequence s_pd_req;
    reg_wr && reg_addr == `OFS_CTRL && reg_wdata[1] && !cpu_halt;
  endsequence
  sequence s_pd_held;
    !osc_run && cpu_halt && can_sleep_set;
  endsequence
  a_pd_entry: assert property (s_pd_req |=> s_pd_held)
    else $error("no power-down after write");
  a_sleep_force: assert property (can_sleep_set == !osc_run)
    else $error("sleep force outside power-down");
  a_pd_kept: assert property (!osc_run && !can_rx_dom |=> !osc_run)
    else $error("power-down left without cause");
  a_pd_exit: assert property (!osc_run ##1 osc_run |-> sys_reset)
    else $error("power-down left without pulse");
  a_pulse_min: assert property ($fell(sys_reset) |->
    hi_ff >= WAKE_MC * MC_CLKS)
    else $error("wake pulse too short");
  a_pin_drive: assert property (sys_reset |->
    reset_pin_out && !reset_pin_oe_n)
    else $error("reset pin not driven");
  a_can_kept: assert property (sys_reset &&
    hi_ff < CAN_RST_MC * MC_CLKS |-> !can_reset)
    else $error("CAN reset too early");
  a_can_part: assert property (sys_reset &&
    hi_ff == (CAN_RST_MC + 2) * MC_CLKS + 1 |-> can_reset)
    else $error("CAN reset missing");
  a_idle_pins: assert property (cpu_halt && osc_run && !sys_reset |->
    ale_pin && program_store_strobe && pwm_pin == 2'b11 && port_hold)
    else $error("idle pins wrong");
  a_pd_pins: assert property (!osc_run |-> !ale_pin &&
    !program_store_strobe && pwm_pin == 2'b11 && port_hold && !port2_addr)
    else $error("power-down pins wrong");
  a_tx_recessive: assert property ($past(can_tx_is_out) && !osc_run |->
    can_tx_out0 && can_tx_out1)
    else $error("tx not recessive");
endmodule
bind power_down_wakeup_control pdwake_asserts #(.WAKE_MC(WAKE_MC),
  .CAN_RST_MC(CAN_RST_MC), .MC_CLKS(MC_CLKS)) i_pdwake_asserts (
  .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .can_rx_dom,
  .can_tx_is_out, .osc_run, .cpu_halt, .sys_reset, .can_reset,
  .can_sleep_set, .reset_pin_out, .reset_pin_oe_n, .ale_pin,
  .program_store_strobe, .pwm_pin, .port2_addr, .port_hold,
  .can_tx_out0, .can_tx_out1);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for power-down and CAN wake-up.
// Assumes: Short counts 6, 8 and 2.
// Notes: Reads checked from a queue of expected words.
`timescale 1ns/100ps
`default_nettype none
`include "pdwake_params.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_ff = 1'b0;
  logic can_asleep = 1'b0;
  logic cpu_irq_any = 1'b0;
  logic send_dom = 1'b0;
  logic long_cap = 1'b0;
  logic ext_prog = 1'b1;
  logic tx_out = 1'b1;
  logic [7:0] core = 8'h00;
  logic [31:0] seed = 32'heede1d1a;
  logic [31:0] ien_v [3] = '{32'h0, 32'h80, 32'h20};
  logic [31:0] exp_q [$];
  logic [31:0] reg_rdata;
  logic [1:0] pwm_pin;
  logic can_rx_dom, rst_pin_in, reset_pin_out, reset_pin_oe_n, osc_run;
  logic cpu_halt, sys_reset, can_reset, can_sleep_set, ale_pin, crs;
  logic program_store_strobe, port0_float, port2_addr, port_hold;
  logic can_tx_out0, can_tx_out1, irq;
  int failures = 0;
  int checks_done = 0;
  int n;
  // Short counts keep the wake pulse to about a dozen clocks
  power_down_wakeup_control #(.WAKE_MC(6), .CAN_RST_MC(8), .MC_CLKS(2))
    i_power_down_wakeup_control (.clk_sys, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .can_rx_dom, .can_asleep,
    .ext_prog, .cpu_irq_any, .can_tx_is_out(tx_out),
    .can_tx_core(core[1:0]), .ale_core(core[7]),
    .program_store_strobe_core(core[6]), .pwm_core(core[5:4]),
    .port2_addr_core(core[2]), .port0_float_core(core[3]), .rst_pin_in,
    .reset_pin_out, .reset_pin_oe_n, .osc_run, .cpu_halt, .sys_reset,
    .can_reset, .can_sleep_set, .ale_pin, .program_store_strobe,
    .pwm_pin, .port0_float, .port2_addr, .port_hold, .can_tx_out0,
    .can_tx_out1, .irq);
  can_bus_model i_can_bus_model (.clk_sys, .send_dom, .long_cap,
    .reset_pin_out, .reset_pin_oe_n, .hw_rst(rst), .can_rx_dom,
    .rst_pin_in);
  initial forever #4 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [12:0] run_pins(input logic i);
    return {i, 3'b100, core[7:2], 1'b0, core[0], core[1]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pins(input logic [12:0] e);
    #1;
    cmp({19'h0, irq, osc_run, cpu_halt, can_sleep_set, ale_pin,
      program_store_strobe, pwm_pin, port0_float, port2_addr, port_hold,
      can_tx_out0, can_tx_out1}, {19'h0, e});
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) rd_ff <= reg_rd;
  always @(negedge clk_sys)
    if (rd_ff && exp_q.size() > 0) cmp(reg_rdata, exp_q.pop_front());
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_STATE, 32'h10);
    rd(8'h14, 32'h0);
    seed = lfsr(seed);
    core <= seed[7:0];
    wr(`OFS_MASK, seed);
    rd(`OFS_MASK, {28'h0, seed[3:0]});
    wr(`OFS_MASK, 32'hf);
    pins(run_pins(1'b0));
    $display("test registers done");
    wr(`OFS_CTRL, 32'h1);
    pins({1'b0, 10'b1101111111, core[0], core[1]});
    cpu_irq_any <= 1'b1;
    @(posedge clk_sys);
    cpu_irq_any <= 1'b0;
    @(posedge clk_sys);
    pins(run_pins(1'b1));
    rd(`OFS_STATUS, 32'h8);
    wr(`OFS_STATUS, 32'h8);
    pins(run_pins(1'b0));
    $display("test idle done");
    // Bus activity without both enables must not wake
    foreach (ien_v[i]) begin
      ext_prog <= i != 1;
      tx_out <= i != 2;
      wr(`OFS_INTERRUPT_ENABLE_REG0, ien_v[i]);
      can_asleep <= 1'b1;
      // Both mode bits at once on the first pass: power-down must win
      wr(`OFS_CTRL, i == 0 ? 32'h3 : 32'h2);
      pins({8'b10110011, ext_prog, 2'b01,
        tx_out ? 2'b11 : {core[0], core[1]}});
      send_dom <= 1'b1;
      @(posedge clk_sys);
      send_dom <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rd(`OFS_STATE, 32'h42);
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      can_asleep <= 1'b0;
      @(posedge clk_sys);
      rd(`OFS_STATUS, 32'h0);
      rd(`OFS_MASK, 32'h0);
      wr(`OFS_MASK, 32'hf);
    end
    $display("test refused wake done");
    // Plain pulse, then one stretched by the capacitor
    for (int c = 0; c < 2; c++) begin
      seed = lfsr(seed);
      core <= seed[7:0];
      long_cap <= c[0];
      wr(`OFS_INTERRUPT_ENABLE_REG0, 32'ha0);
      wr(`OFS_CTRL, 32'h2);
      send_dom <= 1'b1;
      @(posedge clk_sys);
      send_dom <= 1'b0;
      n = 0;
      crs = 1'b0;
      repeat (80) begin
        @(posedge clk_sys);
        #1;
        n += sys_reset;
        crs |= can_reset;
      end
      cmp({31'h0, sys_reset}, 32'h0);
      cmp({31'h0, c ? n > 38 : n >= 13 && n <= 14}, 32'h1);
      cmp({31'h0, crs}, c);
      @(posedge clk_sys);
      rd(`OFS_INTERRUPT_ENABLE_REG0, 32'h0);
      rd(`OFS_STATUS, c ? 32'h7 : 32'h3);
      rd(`OFS_MASK, 32'hf);
      pins(run_pins(1'b1));
      wr(`OFS_STATUS, 32'h7);
    end
    $display("test wake done");
    finish_test();
  end
endmodule
`default_nettype wire
